// *** rtl/flash_status_config_regs.sv ***
/*
  Status and configuration registers of a serial NOR flash, with the
  write-enable, status-write and address-mode commands that change them.
  Assumes the serial pins are asynchronous to ref_clk_in and that the
  serial clock runs well below a quarter of the system clock rate.
*/
`timescale 1ns/1ps

module flash_status_config_regs
  import flash_regs_pkg::*;
#(
  parameter int WRITE_CYCLES      = STATUS_WRITE_CYCLES,
  parameter bit TOP_SPEED_SUPPORT = 1'b0
) (
  // clock and power-on reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  // serial command pins
  input  wire logic                 select_n_in,
  input  wire logic                 sclk_in,
  input  wire logic                 mosi_in,
  input  wire logic                 write_protect_io2_n_in,
  // register contents
  output flash_status_t             status_out,
  output flash_configuration_t      config_out,
  output logic                      hw_protect_mode_out,
  // dummy clock counts for the read paths
  output logic [3:0]                fast_dummy_out,
  output logic [3:0]                dual_io_dummy_out,
  output logic [3:0]                quad_io_dummy_out
);

  regs_state_t s_reg;
  regs_state_t s_next;

  logic sclk_rise;
  logic sel_rise;
  logic sel_fall;
  logic status_write_cmd_go;
  logic len_ok;

  assign sclk_rise = s_reg.sclk_s2 & ~s_reg.sclk_d;
  assign sel_rise  = s_reg.sel_s2 & ~s_reg.sel_d;
  assign sel_fall  = ~s_reg.sel_s2 & s_reg.sel_d;
  assign len_ok    = (s_reg.bit_cnt == SW_SHORT_BITS) ||
                     (s_reg.bit_cnt == SW_LONG_BITS);
  assign status_write_cmd_go   = sel_rise && !s_reg.stat.write_busy &&
                     (s_reg.opcode == STATUS_WRITE_CMD) && len_ok &&
                     s_reg.stat.write_enable_latch && !s_reg.hw_protect_mode;

  always_comb begin
    flash_status_t        sb;
    flash_configuration_t cb;
    sb = '0;
    cb = '0;
    s_next = s_reg;
    // pins pass two flops; the first is read only by the second, except wp_s1, which hw_protect_mode also reads
    s_next.sclk_s1 = sclk_in;
    s_next.sclk_s2 = s_reg.sclk_s1;
    s_next.sclk_d  = s_reg.sclk_s2;
    s_next.sel_s1  = select_n_in;
    s_next.sel_s2  = s_reg.sel_s1;
    s_next.sel_d   = s_reg.sel_s2;
    s_next.mosi_s1 = mosi_in;
    s_next.mosi_s2 = s_reg.mosi_s1;
    s_next.wp_s1   = write_protect_io2_n_in;
    s_next.wp_s2   = s_reg.wp_s1;

    // shift in opcode, then data bits; the count saturates on long frames
    if (sel_fall) begin
      s_next.bit_cnt = '0;
      s_next.opcode  = '0;
    end else if (sclk_rise && !s_reg.sel_s2) begin
      if (s_reg.bit_cnt < OPCODE_BITS) begin
        s_next.opcode = {s_reg.opcode[6:0], s_reg.mosi_s2};
      end else begin
        s_next.data = {s_reg.data[14:0], s_reg.mosi_s2};
      end
      if (s_reg.bit_cnt != BIT_CNT_MAX) begin
        s_next.bit_cnt = s_reg.bit_cnt + 6'h01;
      end
    end

    // a 16-bit frame carries only the status byte
    if (s_reg.bit_cnt == SW_LONG_BITS) begin
      sb = s_reg.data[15:8];
      cb = s_reg.data[7:0];
    end else begin
      sb = s_reg.data[7:0];
      cb = s_reg.cfg;
    end

    // commands act on select release; all are ignored while busy
    if (sel_rise && !s_reg.stat.write_busy &&
        s_reg.bit_cnt == OPCODE_BITS) begin
      case (s_reg.opcode)
        WRITE_ENABLE_CMD: begin
          s_next.stat.write_enable_latch = 1'b1;
        end
        ENTER_ADDR32_CMD: begin
          s_next.cfg.addr32_mode = 1'b1;
        end
        EXIT_ADDR32_CMD: begin
          s_next.cfg.addr32_mode = 1'b0;
        end
        default: begin
        end
      endcase
    end

    if (status_write_cmd_go) begin
      // latch and busy bits of the byte are dropped
      s_next.stat.status_write_lock = sb.status_write_lock;
      s_next.stat.quad_io_enable    = sb.quad_io_enable;
      s_next.stat.protect_level     = sb.protect_level;
      if (cb.dummy_count_sel != DUMMY_TOP_SPEED || TOP_SPEED_SUPPORT) begin
        s_next.cfg.dummy_count_sel = cb.dummy_count_sel;
      end
      // once set a status write cannot clear it; only reset does
      s_next.cfg.protect_from_bottom = s_reg.cfg.protect_from_bottom |
                                       cb.protect_from_bottom;
      // reserved codes leave the old strength in place
      if (cb.drive_strength_sel != DRIVE_RSVD_LO &&
          cb.drive_strength_sel != DRIVE_RSVD_HI) begin
        s_next.cfg.drive_strength_sel = cb.drive_strength_sel;
      end
      s_next.stat.write_busy = 1'b1;
      s_next.timer = 16'(WRITE_CYCLES - 1);
    end else if (s_reg.stat.write_busy) begin
      if (s_reg.timer == '0) begin
        s_next.stat.write_busy         = 1'b0;
        s_next.stat.write_enable_latch = 1'b0;
      end else begin
        s_next.timer = s_reg.timer - 16'h0001;
      end
    end

    s_next.cfg.reserved = 1'b0;
    // uses the synchronised pin, so it lags the pin by two cycles
    s_next.hw_protect_mode = s_next.stat.status_write_lock & ~s_next.wp_s2;
    s_next.fast_dummy = FAST_DUMMY[s_next.cfg.dummy_count_sel];
    s_next.dio_dummy  = DIO_DUMMY[s_next.cfg.dummy_count_sel];
    s_next.qio_dummy  = QIO_DUMMY[s_next.cfg.dummy_count_sel];
  end

  // power-on reset restores every volatile default
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // contents visible at all times, busy included
  assign status_out          = s_reg.stat;
  assign config_out          = s_reg.cfg;
  assign hw_protect_mode_out = s_reg.hw_protect_mode;
  assign fast_dummy_out      = s_reg.fast_dummy;
  assign dual_io_dummy_out   = s_reg.dio_dummy;
  assign quad_io_dummy_out   = s_reg.qio_dummy;

  sequence seq_write_start;
    $rose(s_reg.stat.write_busy);
  endsequence

  sequence seq_refused_write;
    sel_rise && (s_reg.opcode == STATUS_WRITE_CMD) &&
      (s_reg.hw_protect_mode || !s_reg.stat.write_enable_latch || !len_ok);
  endsequence

  property p_busy_holds;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      seq_write_start |-> s_reg.stat.write_busy [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("write_busy dropped early in write cycle");

  property p_end_clears_latch;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      $fell(s_reg.stat.write_busy) |-> !s_reg.stat.write_enable_latch;
  endproperty
  a_end_clears_latch: assert property (p_end_clears_latch)
    else $error("latch still set after write cycle");

  property p_start_on_release;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      status_write_cmd_go |=> seq_write_start;
  endproperty
  a_start_on_release: assert property (p_start_on_release)
    else $error("write cycle did not start at select release");

  property p_latch_kept;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      seq_write_start |-> s_reg.stat.write_enable_latch;
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("status write changed the latch bit");

  property p_refused;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      seq_refused_write |=> !$rose(s_reg.stat.write_busy) &&
        $stable(s_reg.stat[7:2]) && $stable(s_reg.cfg);
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused status write changed registers");

  property p_no_top_speed;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      !TOP_SPEED_SUPPORT |-> s_reg.cfg.dummy_count_sel != DUMMY_TOP_SPEED;
  endproperty
  a_no_top_speed: assert property (p_no_top_speed)
    else $error("dummy code 11 stored without top speed");

  property p_bottom_otp;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      $past(s_reg.cfg.protect_from_bottom) |-> s_reg.cfg.protect_from_bottom;
  endproperty
  a_bottom_otp: assert property (p_bottom_otp)
    else $error("bottom protect bit was cleared");

  property p_drive_legal;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      s_reg.cfg.drive_strength_sel != DRIVE_RSVD_LO &&
      s_reg.cfg.drive_strength_sel != DRIVE_RSVD_HI;
  endproperty
  a_drive_legal: assert property (p_drive_legal)
    else $error("reserved drive code stored");

  property p_dummy_table;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      fast_dummy_out == FAST_DUMMY[config_out.dummy_count_sel] &&
      dual_io_dummy_out == DIO_DUMMY[config_out.dummy_count_sel] &&
      quad_io_dummy_out == QIO_DUMMY[config_out.dummy_count_sel];
  endproperty
  a_dummy_table: assert property (p_dummy_table)
    else $error("dummy count does not match dummy code");

  property p_hpm_def;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_reg.stat.status_write_lock && !s_reg.wp_s2) [*2] |->
        hw_protect_mode_out;
  endproperty
  a_hpm_def: assert property (p_hpm_def)
    else $error("hardware protect not active");

  // load checks read the frame as it stood at select release
  sequence seq_short_write;
    status_write_cmd_go && (s_reg.bit_cnt == SW_SHORT_BITS);
  endsequence

  sequence seq_long_write;
    status_write_cmd_go && (s_reg.bit_cnt == SW_LONG_BITS);
  endsequence

  property p_status_short;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      seq_short_write |=> s_reg.stat[7:2] == $past(s_reg.data[7:2]);
  endproperty
  a_status_short: assert property (p_status_short)
    else $error("short status write did not load status bits");

  property p_status_long;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      seq_long_write |=> s_reg.stat[7:2] == $past(s_reg.data[15:10]);
  endproperty
  a_status_long: assert property (p_status_long)
    else $error("long status write did not load status bits");

  property p_short_keeps_cfg;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      seq_short_write |=> $stable(s_reg.cfg);
  endproperty
  a_short_keeps_cfg: assert property (p_short_keeps_cfg)
    else $error("short status write changed configuration");

  property p_bottom_load;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      seq_long_write |=> s_reg.cfg.protect_from_bottom ==
        ($past(s_reg.cfg.protect_from_bottom) | $past(s_reg.data[3]));
  endproperty
  a_bottom_load: assert property (p_bottom_load)
    else $error("bottom protect bit not loaded");

  property p_timer_load;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      status_write_cmd_go |=> s_reg.timer == 16'(WRITE_CYCLES - 1);
  endproperty
  a_timer_load: assert property (p_timer_load)
    else $error("write cycle timer not loaded");

  // the cycle length is too long for a repetition, so the timer is watched
  property p_timer_count;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_reg.stat.write_busy && s_reg.timer != 16'h0000) |=>
        s_reg.stat.write_busy &&
        s_reg.timer == $past(s_reg.timer) - 16'h0001;
  endproperty
  a_timer_count: assert property (p_timer_count)
    else $error("write cycle timer did not count down");

  property p_busy_drop;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      $fell(s_reg.stat.write_busy) |-> $past(s_reg.timer) == 16'h0000;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("write_busy dropped before timer expiry");

  property p_dummy_by_write;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      $changed(s_reg.cfg.dummy_count_sel) |-> $past(status_write_cmd_go);
  endproperty
  a_dummy_by_write: assert property (p_dummy_by_write)
    else $error("dummy code changed outside a status write");

  property p_addr32_enter;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      $rose(s_reg.cfg.addr32_mode) |->
        $past(s_reg.opcode) == ENTER_ADDR32_CMD;
  endproperty
  a_addr32_enter: assert property (p_addr32_enter)
    else $error("addr32 mode set without enter command");

  property p_addr32_exit;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      $fell(s_reg.cfg.addr32_mode) |->
        $past(s_reg.opcode) == EXIT_ADDR32_CMD;
  endproperty
  a_addr32_exit: assert property (p_addr32_exit)
    else $error("addr32 mode cleared without exit command");

endmodule

// *** rtl/flash_regs_pkg.sv ***
/*
  Shared constants and carrier types for the flash status and configuration
  register pair and its serial command front end.
  Assumes a single 200 MHz system clock; the serial pins are asynchronous.
*/
package flash_regs_pkg;

  // command opcodes
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ENTER_ADDR32_CMD = 8'hB7;
  localparam logic [7:0] EXIT_ADDR32_CMD  = 8'hE9;

  // bit counts seen at select release (opcode included)
  localparam logic [5:0] OPCODE_BITS      = 6'h08;
  localparam logic [5:0] SW_SHORT_BITS    = 6'h10;
  localparam logic [5:0] SW_LONG_BITS     = 6'h18;
  localparam logic [5:0] BIT_CNT_MAX      = 6'h3F;

  // special field codes
  localparam logic [1:0] DUMMY_TOP_SPEED  = 2'h3;
  localparam logic [2:0] DRIVE_RSVD_LO    = 3'h0;
  localparam logic [2:0] DRIVE_RSVD_HI    = 3'h4;

  // timing
  localparam int STATUS_WRITE_TIME_NS     = 10000;
  localparam int CLK_FREQ_MHZ             = 200;
  localparam int STATUS_WRITE_CYCLES      =
    (STATUS_WRITE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  // dummy clocks per dummy_count_sel code, index 0..3
  localparam logic [3:0] FAST_DUMMY [0:3] = '{4'h8, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DIO_DUMMY  [0:3] = '{4'h4, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] QIO_DUMMY  [0:3] = '{4'h6, 4'h4, 4'h8, 4'hA};

  typedef struct packed {
    logic       status_write_lock;
    logic       quad_io_enable;
    logic [3:0] protect_level;
    logic       write_enable_latch;
    logic       write_busy;
  } flash_status_t;

  typedef struct packed {
    logic [1:0] dummy_count_sel;
    logic       addr32_mode;
    logic       reserved;
    logic       protect_from_bottom;
    logic [2:0] drive_strength_sel;
  } flash_configuration_t;

  localparam flash_status_t        STATUS_RESET = 8'h00;
  localparam flash_configuration_t CONFIG_RESET = 8'h07;

  typedef struct packed {
    logic                 sclk_s1;
    logic                 sclk_s2;
    logic                 sclk_d;
    logic                 sel_s1;
    logic                 sel_s2;
    logic                 sel_d;
    logic                 mosi_s1;
    logic                 mosi_s2;
    logic                 wp_s1;
    logic                 wp_s2;
    logic [5:0]           bit_cnt;
    logic [7:0]           opcode;
    logic [15:0]          data;
    logic [15:0]          timer;
    flash_status_t        stat;
    flash_configuration_t cfg;
    logic                 hw_protect_mode;
    logic [3:0]           fast_dummy;
    logic [3:0]           dio_dummy;
    logic [3:0]           qio_dummy;
  } regs_state_t;

  localparam regs_state_t STATE_RESET = '{
    sel_s1: 1'b1, sel_s2: 1'b1, sel_d: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1,
    stat: STATUS_RESET, cfg: CONFIG_RESET,
    fast_dummy: FAST_DUMMY[0], dio_dummy: DIO_DUMMY[0],
    qio_dummy: QIO_DUMMY[0],
    default: '0};

endpackage

// *** bench/host_model.sv ***
/*
  Behavioural host controller on the serial command pins: frames opcodes
  and data MSB first, in mode 0, with a 64 ns serial clock.
  Assumes the device samples the pins with its own faster clock.
*/
`timescale 1ns/1ps

module host_model (
  // serial command pins
  output logic select_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  initial begin
    select_n_out = 1'b1;
    sclk_out     = 1'b0;
    mosi_out     = 1'b0;
  end

  // bits are MSB aligned; only the first n go out, so a short count
  // can be sent on purpose to provoke a refusal
  task automatic send(input logic [23:0] bits, input int n);
    select_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_out = bits[23-i];
      #16;
      sclk_out = 1'b1;
      #32;
      sclk_out = 1'b0;
      #16;
    end
    select_n_out = 1'b1;
    // mosi is inverted after release: the last data bit does not stay on the line
    mosi_out = ~mosi_out;
    #40;
  endtask
endmodule

// *** bench/tb.sv ***
/*
  Self-checking bench for the status and configuration register pair.
  Assumes the host model drives the serial pins and the bench the rest.
*/
`timescale 1ns/1ps

module tb;
  import flash_regs_pkg::*;
  localparam int WCYC = 40;
  logic                 ref_clk_in = 1'b0;
  logic                 resetn_in  = 1'b0;
  logic                 wp_n       = 1'b1;
  logic                 select_n, sclk, mosi, hw_protect_mode;
  logic [3:0]           fd, dd, qd;
  logic [7:0]           c;
  flash_status_t        status, exp_s;
  flash_configuration_t cfg, exp_c;
  int                   failures = 0;
  int                   samples_checked = 0;
  integer               seed;

  always #2.5 ref_clk_in = ~ref_clk_in;

  host_model host (.select_n_out(select_n), .sclk_out(sclk),
                   .mosi_out(mosi));

  flash_status_config_regs #(.WRITE_CYCLES(WCYC)) uut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .select_n_in(select_n), .sclk_in(sclk), .mosi_in(mosi),
    .write_protect_io2_n_in(wp_n), .status_out(status),
    .config_out(cfg), .hw_protect_mode_out(hw_protect_mode),
    .fast_dummy_out(fd), .dual_io_dummy_out(dd),
    .quad_io_dummy_out(qd));

  task automatic check8(input logic [7:0] act, input logic [7:0] exp);
    samples_checked++;
    if (act !== exp) begin
      failures++;
      $display("mismatch t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  task automatic check_all();
    check8(status, exp_s);
    check8(cfg, exp_c);
    check8({4'h0, fd}, {4'h0, FAST_DUMMY[exp_c.dummy_count_sel]});
    check8({4'h0, dd}, {4'h0, DIO_DUMMY[exp_c.dummy_count_sel]});
    check8({4'h0, qd}, {4'h0, QIO_DUMMY[exp_c.dummy_count_sel]});
  endtask

  task automatic cmd(input logic [23:0] b, input int n);
    host.send(b, n);
    idle(8);
  endtask

  task automatic we();
    cmd({WRITE_ENABLE_CMD, 16'h0000}, 8);
    exp_s.write_enable_latch = 1'b1;
    check_all();
  endtask

  // reserved drive codes and the top-speed dummy code keep the old value
  function automatic flash_configuration_t next_cfg(
    input flash_configuration_t o, input logic [7:0] b);
    next_cfg = o;
    if (b[7:6] != DUMMY_TOP_SPEED) next_cfg.dummy_count_sel = b[7:6];
    next_cfg.protect_from_bottom = o.protect_from_bottom | b[3];
    if (b[2:0] != DRIVE_RSVD_LO && b[2:0] != DRIVE_RSVD_HI)
      next_cfg.drive_strength_sel = b[2:0];
  endfunction

  task automatic wsr(input logic [7:0] s, input logic [7:0] cb,
                     input bit long, input bit ok);
    cmd({STATUS_WRITE_CMD, s, cb}, long ? 24 : 16);
    if (ok) begin
      exp_s[7:2] = s[7:2];
      exp_s.write_busy = 1'b1;
      if (long) exp_c = next_cfg(exp_c, cb);
    end
    check_all();
    if (ok) begin
      for (int k = 0; k < WCYC + 20 && status.write_busy !== 1'b0; k++)
        idle(1);
      exp_s.write_busy = 1'b0;
      exp_s.write_enable_latch = 1'b0;
      check_all();
    end
  endtask

  task automatic complete_run();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    complete_run();
  end

  initial begin
    seed = 32'h48ACA791;
    exp_s = STATUS_RESET;
    exp_c = CONFIG_RESET;
    idle(6);
    resetn_in = 1'b1;
    idle(4);
    check_all();
    $display("test reset done");
    wsr(8'h3C, 8'h00, 1'b0, 1'b0);
    we();
    wsr($random(seed) & 8'h7F, 8'h00, 1'b0, 1'b1);
    $display("test short write done");
    for (int i = 0; i < 4; i++) begin
      we();
      c = $random(seed);
      c[7:6] = i[1:0];
      if (i == 1) c[2:0] = DRIVE_RSVD_HI;
      if (i == 2) c[2:0] = DRIVE_RSVD_LO;
      if (i == 0) c[3] = 1'b1;
      if (i == 3) c[3] = 1'b0;
      wsr($random(seed) & 8'h7F, c, 1'b1, 1'b1);
    end
    $display("test config write done");
    we();
    cmd({STATUS_WRITE_CMD, 16'hFFFF}, 20);
    check_all();
    wsr(8'h80 | ($random(seed) & 8'h3C), 8'h00, 1'b0, 1'b1);
    $display("test bit count done");
    cmd({ENTER_ADDR32_CMD, 16'h0000}, 8);
    exp_c.addr32_mode = 1'b1;
    check_all();
    cmd({EXIT_ADDR32_CMD, 16'h0000}, 8);
    exp_c.addr32_mode = 1'b0;
    check_all();
    $display("test address mode done");
    wp_n = 1'b0;
    idle(8);
    check8({7'h00, hw_protect_mode}, 8'h01);
    we();
    wsr(8'h00, 8'h05, 1'b1, 1'b0);
    wp_n = 1'b1;
    idle(8);
    check8({7'h00, hw_protect_mode}, 8'h00);
    $display("test protect done");
    complete_run();
  end
endmodule
